// ### shared/cam_pkg.sv
// constants for the counter array module mode block
package cam_pkg;

  // number of capture/compare modules sharing the time base
  localparam int unsigned CAM_NMOD = 5;

  // register indices; byte address is four times the index
  localparam logic [7:0] CAM_IDX_CTRL = 8'hC0;
  localparam logic [7:0] CAM_IDX_CMODE = 8'hC1;
  localparam logic [7:0] CAM_IDX_MODULE0_MODE_CONTROL = 8'hC2;
  localparam logic [7:0] CAM_IDX_MODULE1_MODE_CONTROL = 8'hC3;
  localparam logic [7:0] CAM_IDX_MODULE2_MODE_CONTROL = 8'hC4;
  localparam logic [7:0] CAM_IDX_MODULE3_MODE_CONTROL = 8'hC5;
  localparam logic [7:0] CAM_IDX_MODULE4_MODE_CONTROL = 8'hC6;
  localparam logic [7:0] CAM_IDX_TB = 8'hC8;
  localparam logic [7:0] CAM_IDX_CMP_BASE = 8'hD0;

  // module mode register fields
  localparam int unsigned CAM_MB_ECCF = 0;
  localparam int unsigned CAM_MB_PWM = 1;
  localparam int unsigned CAM_MB_TOG = 2;
  localparam int unsigned CAM_MB_MAT = 3;
  localparam int unsigned CAM_MB_CAPN = 4;
  localparam int unsigned CAM_MB_CAPP = 5;
  localparam int unsigned CAM_MB_ECOM = 6;
  localparam logic [7:0] CAM_MODE_RST = 8'h00;
  localparam logic [7:0] CAM_MODE_WMASK = 8'h7F;

  // control and counter mode fields
  localparam int unsigned CAM_CTRL_RUN = 6;
  localparam int unsigned CAM_CMODE_WATCHDOG_ENABLE = 6;

  // only this module may act as watchdog
  localparam int unsigned CAM_WDT_MOD = 4;

endpackage : cam_pkg

// ### src/cam_top.sv
// counter array: shared time base, five capture/compare/pwm modules, apb registers
//
// Behaviour
// - rising pin edge captures time base
// - falling pin edge captures time base
// - both edge bits capture any transition
// - capture copies high and low bytes
// - captured flag with enable raises interrupt
// - comparator plus match gives software timer
// - timer match sets flag, interrupt if enabled
// - toggle mode inverts pin on match
// - pulse width plus comparator drives pin
// - pin low below compare byte, else high
// - low byte reloads from high at wrap
// - all pwm modules share one frequency
// - only module four can be watchdog
// - watchdog needs compare mode and enable
// - watchdog match issues internal reset
// - watchdog reset never drives reset pin
// - clearing enable prevents reset, setting rearms
// - event flags set by hardware, software clears
// - time base counts only while run set
`timescale 1ns/1ns

module cam_top
  import cam_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_tick,
  input wire logic [4:0] module_pin_in,
  output logic [4:0] module_pin_out,
  output logic [4:0] module_pin_oe,
  output logic counter_irq,
  output logic watchdog_reset
);

  ////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [15:0] tb;
    logic run;
    logic [4:0] flags;
    logic wdt_en;
    logic [4:0][7:0] mode;
    logic [4:0][7:0] cmp_hi;
    logic [4:0][7:0] cmp_lo;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] prev;
    logic [4:0] pin_out;
    logic [4:0] pin_oe;
    logic wdt_rst;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cam_state_t;

  cam_state_t s_q;
  cam_state_t s_d;

  logic wr;
  logic setup;
  logic tick;
  logic tb_wr;
  logic mapped;
  logic [7:0] idx;
  logic [31:0] rd;
  logic [4:0] cap_ev;
  logic [4:0] hit;
  logic [4:0] cmp_md;
  logic [4:0] pwm_md;
  logic [4:0] ecc;

  ////////////////////////////////////////////////////////////////////
  // next state

  // one pass: bus writes first, hardware events after so a set beats a clear
  always_comb begin
    s_d = s_q;
    idx = paddr[9:2];
    setup = psel & ~penable;
    wr = psel & penable & s_q.pready & pwrite & (paddr[11:10] == 2'b00);
    tick = count_tick & s_q.run;
    tb_wr = wr & (idx == CAM_IDX_TB);
    cap_ev = 5'h00;
    hit = 5'h00;
    cmp_md = 5'h00;
    pwm_md = 5'h00;
    ecc = 5'h00;
    mapped = 1'b0;
    rd = 32'h0000_0000;
    s_d.wdt_rst = 1'b0;

    // pins pass two flops; prev is the edge reference, never sync1
    s_d.sync1 = module_pin_in;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;

    // software writes to control and counter mode
    if (wr && idx == CAM_IDX_CTRL) begin
      s_d.run = pwdata[CAM_CTRL_RUN];
      s_d.flags = s_q.flags & pwdata[4:0];
    end
    if (wr && idx == CAM_IDX_CMODE) begin
      s_d.wdt_en = pwdata[CAM_CMODE_WATCHDOG_ENABLE];
    end

    // time base: a software load wins over the count
    if (tb_wr) begin
      s_d.tb = pwdata[15:0];
    end else if (tick) begin
      s_d.tb = s_q.tb + 16'h0001;
    end

    for (int i = 0; i < 5; i++) begin
      if (wr && idx == CAM_IDX_MODULE0_MODE_CONTROL + 8'(i)) begin
        s_d.mode[i] = pwdata[7:0] & CAM_MODE_WMASK;
      end
      if (wr && idx == CAM_IDX_CMP_BASE + 8'(i)) begin
        s_d.cmp_hi[i] = pwdata[15:8];
        s_d.cmp_lo[i] = pwdata[7:0];
      end

      // mode decode; an all-zero mode matches none of these
      cap_ev[i] = ~s_q.mode[i][CAM_MB_MAT] & ~s_q.mode[i][CAM_MB_TOG]
        & ~s_q.mode[i][CAM_MB_PWM]
        & ((s_q.mode[i][CAM_MB_CAPP] & s_q.sync2[i] & ~s_q.prev[i])
        | (s_q.mode[i][CAM_MB_CAPN] & ~s_q.sync2[i] & s_q.prev[i]));
      cmp_md[i] = s_q.mode[i][CAM_MB_ECOM] & s_q.mode[i][CAM_MB_MAT]
        & ~s_q.mode[i][CAM_MB_PWM] & ~s_q.mode[i][CAM_MB_CAPP]
        & ~s_q.mode[i][CAM_MB_CAPN];
      pwm_md[i] = s_q.mode[i][CAM_MB_ECOM] & s_q.mode[i][CAM_MB_PWM]
        & ~s_q.mode[i][CAM_MB_MAT] & ~s_q.mode[i][CAM_MB_TOG]
        & ~s_q.mode[i][CAM_MB_CAPP] & ~s_q.mode[i][CAM_MB_CAPN];

      // one compare per count, all sixteen bits
      hit[i] = tick & (s_q.tb == {s_q.cmp_hi[i], s_q.cmp_lo[i]});

      // capture beats a software write to the same compare word
      if (cap_ev[i]) begin
        s_d.cmp_hi[i] = s_q.tb[15:8];
        s_d.cmp_lo[i] = s_q.tb[7:0];
        s_d.flags[i] = 1'b1;
      end

      // software timer and high speed output
      if (cmp_md[i] && hit[i]) begin
        s_d.flags[i] = 1'b1;
        if (s_q.mode[i][CAM_MB_TOG]) begin
          s_d.pin_out[i] = ~s_q.pin_out[i];
        end
      end

      // pwm: shared time base sets the period, own byte the duty
      if (pwm_md[i]) begin
        s_d.pin_out[i] = (s_q.tb[7:0] >= s_q.cmp_lo[i]);
        if (tick && s_q.tb[7:0] == 8'hFF) begin
          s_d.cmp_lo[i] = s_q.cmp_hi[i];
        end
      end
      s_d.pin_oe[i] = (cmp_md[i] & s_q.mode[i][CAM_MB_TOG]) | pwm_md[i];

      // watchdog only on module four; otherwise module four is ordinary
      if (i == CAM_WDT_MOD && cmp_md[i] && s_q.wdt_en && hit[i]) begin
        s_d.wdt_rst = 1'b1;
      end
      ecc[i] = s_d.mode[i][CAM_MB_ECCF];
    end

    // interrupt follows the flags and enables of the next state
    s_d.irq = |(s_d.flags & ecc);

    // read mux; data is snapshotted in the setup cycle
    if (paddr[11:10] == 2'b00) begin
      if (idx == CAM_IDX_CTRL) begin
        rd = {24'h00_0000, 1'b0, s_q.run, 1'b0, s_q.flags};
        mapped = 1'b1;
      end
      if (idx == CAM_IDX_CMODE) begin
        rd = {24'h00_0000, 1'b0, s_q.wdt_en, 6'h00};
        mapped = 1'b1;
      end
      if (idx == CAM_IDX_TB) begin
        rd = {16'h0000, s_q.tb};
        mapped = 1'b1;
      end
      for (int i = 0; i < 5; i++) begin
        if (idx == CAM_IDX_MODULE0_MODE_CONTROL + 8'(i)) begin
          rd = {24'h00_0000, s_q.mode[i]};
          mapped = 1'b1;
        end
        if (idx == CAM_IDX_CMP_BASE + 8'(i)) begin
          rd = {16'h0000, s_q.cmp_hi[i], s_q.cmp_lo[i]};
          mapped = 1'b1;
        end
      end
    end

    // fixed one-cycle access phase
    s_d.pready = setup;
    s_d.pslverr = setup & ~mapped;
    if (setup) begin
      s_d.prdata = pwrite ? 32'h0000_0000 : rd;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // every output straight from the state; reset stays internal
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign module_pin_out = s_q.pin_out;
  assign module_pin_oe = s_q.pin_oe;
  assign counter_irq = s_q.irq;
  assign watchdog_reset = s_q.wdt_rst;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rise_capture_a: assert property (
    (s_q.mode[1] & 8'h3E) == 8'h20 && s_q.sync2[1] && !s_q.prev[1]
    |=> {s_q.cmp_hi[1], s_q.cmp_lo[1]} == $past(s_q.tb) && s_q.flags[1])
    else $error("rising edge capture missed");

  fall_capture_a: assert property (
    (s_q.mode[2] & 8'h3E) == 8'h10 && !s_q.sync2[2] && s_q.prev[2]
    |=> {s_q.cmp_hi[2], s_q.cmp_lo[2]} == $past(s_q.tb) && s_q.flags[2])
    else $error("falling edge capture missed");

  both_edges_a: assert property (
    (s_q.mode[3] & 8'h3E) == 8'h30 && s_q.sync2[3] != s_q.prev[3]
    |=> s_q.cmp_hi[3] == $past(s_q.tb[15:8]) && s_q.cmp_lo[3] == $past(s_q.tb[7:0]))
    else $error("transition capture missed");

  timer_irq_a: assert property (
    s_q.mode[0] == 8'h49 && hit[0] && !wr
    |=> s_q.flags[0] && counter_irq)
    else $error("timer match did not flag and interrupt");

  toggle_pin_a: assert property (
    s_q.mode[3] == 8'h4C && hit[3]
    |=> module_pin_out[3] != $past(module_pin_out[3]) && module_pin_oe[3])
    else $error("output did not toggle on match");

  pwm_level_a: assert property (
    s_q.mode[1] == 8'h42
    |=> module_pin_out[1] == ($past(s_q.tb[7:0]) >= $past(s_q.cmp_lo[1])))
    else $error("pwm level wrong");

  pwm_reload_a: assert property (
    s_q.mode[1] == 8'h42 && tick && s_q.tb[7:0] == 8'hFF && !wr
    |=> s_q.cmp_lo[1] == $past(s_q.cmp_hi[1]))
    else $error("pwm reload missed at wrap");

  wdt_fire_a: assert property (
    s_q.mode[4] == 8'h48 && s_q.wdt_en && hit[4]
    |=> watchdog_reset ##1 !watchdog_reset)
    else $error("watchdog reset not one pulse");

  wdt_off_a: assert property (
    !s_q.wdt_en |=> !watchdog_reset)
    else $error("watchdog fired while disabled");

  run_hold_a: assert property (
    !s_q.run && !tb_wr |=> $stable(s_q.tb))
    else $error("time base moved while stopped");

  flag_hold_a: assert property (
    s_q.flags[0] && !wr |=> s_q.flags[0])
    else $error("flag cleared without software");

  idle_mod_a: assert property (
    s_q.mode[1] == 8'h00 && !wr
    |=> $stable(s_q.flags[1]) && !module_pin_oe[1])
    else $error("idle module acted");

  // flags and interrupt: a flag only ever rises by hardware, and the
  // interrupt is a plain level so software sees it until the flag is cleared

  both_flag_a: assert property (
    (s_q.mode[3] & 8'h3E) == 8'h30 && s_q.sync2[3] != s_q.prev[3]
    |=> s_q.flags[3])
    else $error("transition capture did not flag");

  cap_irq_a: assert property (
    s_q.flags[1] && s_q.mode[1][CAM_MB_ECCF] && !wr
    |=> counter_irq)
    else $error("enabled flag did not interrupt");

  irq_clear_a: assert property (
    s_q.flags == 5'h00 |-> !counter_irq)
    else $error("interrupt without a flag");

  flags_keep_a: assert property (
    !wr |=> (s_q.flags & $past(s_q.flags)) == $past(s_q.flags))
    else $error("flag dropped without software");

  flag_sw_a: assert property (
    wr && idx == CAM_IDX_CTRL && cap_ev == 5'h00 && (cmp_md & hit) == 5'h00
    |=> (s_q.flags & ~$past(s_q.flags)) == 5'h00)
    else $error("software set a flag");

  // compare and watchdog: module four resets only from a full compare hit
  // with the enable set, so a stray low byte match must stay harmless

  hso_flag_a: assert property (
    s_q.mode[3] == 8'h4C && hit[3]
    |=> s_q.flags[3])
    else $error("compare match did not flag");

  hso_quiet_a: assert property (
    s_q.mode[3] == 8'h4C && !hit[3]
    |=> $stable(module_pin_out[3]))
    else $error("output moved without a match");

  wdt_module_a: assert property (
    watchdog_reset
    |-> $past(cmp_md[4]) && $past(s_q.wdt_en) && $past(hit[4]))
    else $error("watchdog reset without module four match");

  wdt_cmp_a: assert property (
    !s_q.mode[4][CAM_MB_MAT] || !s_q.mode[4][CAM_MB_ECOM]
    |=> !watchdog_reset)
    else $error("watchdog fired outside compare mode");

  partial_match_a: assert property (
    s_q.mode[4] == 8'h48 && s_q.wdt_en && s_q.tb[7:0] == s_q.cmp_lo[4]
    && s_q.tb[15:8] != s_q.cmp_hi[4]
    |=> !watchdog_reset)
    else $error("watchdog fired on a partial match");

  idle_pin4_a: assert property (
    s_q.mode[4] == 8'h00
    |=> !module_pin_oe[4] && !watchdog_reset)
    else $error("idle module four acted");

  // pwm and time base: apart from a write to the compare word, the low compare byte moves only at the wrap, which
  // keeps every period whole while software changes the duty

  pwm_oe_a: assert property (
    s_q.mode[1] == 8'h42 |=> module_pin_oe[1])
    else $error("pwm pin not driven");

  pwm_hold_a: assert property (
    s_q.mode[1] == 8'h42 && !tick && !wr
    |=> $stable(s_q.cmp_lo[1]))
    else $error("pwm duty moved outside the wrap");

  tb_count_a: assert property (
    s_q.run && count_tick && !tb_wr
    |=> s_q.tb == $past(s_q.tb) + 16'h0001)
    else $error("time base missed a count");

  tb_load_a: assert property (
    tb_wr |=> s_q.tb == $past(pwdata[15:0]))
    else $error("time base load lost");

endmodule : cam_top

// ### sim/cam_pin_model.sv
// external pin driver model for the module pins
`timescale 1ns/1ns

module cam_pin_model (
  input wire logic pclk,
  input wire logic [4:0] lvl,
  output logic [4:0] pin
);
  // pins move just after a clock edge, never on it
  always @(posedge pclk) begin
    pin <= lvl;
  end
endmodule : cam_pin_model

// ### sim/cam_top_tb.sv
// self-checking bench for the counter array block
`timescale 1ns/1ns

module cam_top_tb;
  import cam_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv, t0;
  logic pready, pslverr, count_tick = 0, tick_en = 0, irq, wrst, ev;
  logic [4:0] lvl = 5'h00, pin_in, pin_out, pin_oe;
  int fails = 0, n_checks = 0, wdt_n = 0;

  cam_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_tick(count_tick), .module_pin_in(pin_in),
    .module_pin_out(pin_out), .module_pin_oe(pin_oe), .counter_irq(irq),
    .watchdog_reset(wrst));
  cam_pin_model pin_u (.pclk(pclk), .lvl(lvl), .pin(pin_in));

  initial forever #5 pclk = ~pclk;
  // tick every other cycle, so a match lasts one tick only
  always @(posedge pclk) begin
    count_tick <= tick_en & ~count_tick;
    if (wrst === 1'b1) wdt_n++;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(logic w, logic [7:0] idx, logic [31:0] wd, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rv = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      fails++;
      stop_test();
    end
  endtask : apb

  task automatic wr(logic [7:0] idx, logic [31:0] d);
    apb(1, idx, d, ev);
  endtask : wr

  task automatic rd(string nm, logic [7:0] idx, logic [31:0] exp);
    apb(0, idx, 0, ev);
    chk(nm, rv, exp);
  endtask : rd

  task automatic cap(logic [15:0] tb, logic [4:0] l, logic [7:0] m, logic [15:0] exp);
    wr(CAM_IDX_TB, {16'h0, tb});
    lvl <= l;
    repeat (6) @(posedge pclk);
    rd("capture", CAM_IDX_CMP_BASE + m, {16'h0, exp});
  endtask : cap

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rd("mode1 reset", CAM_IDX_MODULE1_MODE_CONTROL, 32'h0);
    apb(0, 8'h3F, 0, ev);
    chk("unmapped err", ev, 1);
    lvl <= 5'h04;
    wr(CAM_IDX_MODULE1_MODE_CONTROL, 32'h21);
    wr(CAM_IDX_MODULE2_MODE_CONTROL, 32'h10);
    wr(CAM_IDX_MODULE3_MODE_CONTROL, 32'h30);
    cap(16'h1234, 5'h06, 1, 16'h1234);
    rd("flags", CAM_IDX_CTRL, 32'h02);
    chk("irq", irq, 1);
    cap(16'h2222, 5'h04, 1, 16'h1234);
    cap(16'h0055, 5'h00, 2, 16'h0055);
    cap(16'h0101, 5'h08, 3, 16'h0101);
    cap(16'h0202, 5'h00, 3, 16'h0202);
    wr(CAM_IDX_CTRL, 32'h0);
    rd("flag clear", CAM_IDX_CTRL, 32'h0);
    chk("irq off", irq, 0);
    // timer, toggle and watchdog in one run of the time base
    wr(CAM_IDX_CMP_BASE, 32'h0010);
    wr(CAM_IDX_MODULE0_MODE_CONTROL, 32'h49);
    wr(CAM_IDX_CMP_BASE + 8'h03, 32'h0010);
    wr(CAM_IDX_MODULE3_MODE_CONTROL, 32'h4C);
    wr(CAM_IDX_CMP_BASE + 8'h04, 32'h0018);
    wr(CAM_IDX_MODULE4_MODE_CONTROL, 32'h48);
    wr(CAM_IDX_CMODE, 32'h40);
    wr(CAM_IDX_TB, 32'h0);
    tick_en <= 1;
    wr(CAM_IDX_CTRL, 32'h40);
    repeat (80) @(posedge pclk);
    // stop the count; writing ones leaves the flags alone
    wr(CAM_IDX_CTRL, 32'h1F);
    rd("match flags", CAM_IDX_CTRL, 32'h19);
    chk("timer irq", irq, 1);
    chk("toggle pin", pin_out[3], 1);
    chk("toggle oe", pin_oe[3], 1);
    chk("wdt pulse", wdt_n, 1);
    chk("pin1 idle", pin_oe[1], 0);
    apb(0, CAM_IDX_TB, 0, ev);
    t0 = rv;
    repeat (10) @(posedge pclk);
    rd("tb frozen", CAM_IDX_TB, t0);
    wr(CAM_IDX_CMODE, 32'h0);
    wr(CAM_IDX_TB, 32'h0);
    wr(CAM_IDX_CTRL, 32'h40);
    repeat (80) @(posedge pclk);
    chk("wdt off", wdt_n, 1);
    wr(CAM_IDX_CTRL, 32'h0);
    // setting the enable again re-arms the watchdog
    wr(CAM_IDX_CMODE, 32'h40);
    wr(CAM_IDX_TB, 32'h0);
    wr(CAM_IDX_CTRL, 32'h40);
    repeat (80) @(posedge pclk);
    wr(CAM_IDX_CTRL, 32'h0);
    chk("wdt rearmed", wdt_n, 2);
    // main-line code moves the compare ahead of the time base in time
    wr(CAM_IDX_TB, 32'h0);
    wr(CAM_IDX_CTRL, 32'h40);
    repeat (10) @(posedge pclk);
    wr(CAM_IDX_CMP_BASE + 8'h04, 32'h8000);
    repeat (80) @(posedge pclk);
    wr(CAM_IDX_CTRL, 32'h0);
    chk("wdt serviced", wdt_n, 2);
    // pwm output level against the low compare byte
    wr(CAM_IDX_MODULE1_MODE_CONTROL, 32'h42);
    wr(CAM_IDX_CMP_BASE + 8'h01, 32'h8080);
    wr(CAM_IDX_TB, 32'h0090);
    repeat (3) @(posedge pclk);
    chk("pwm high", pin_out[1], 1);
    chk("pwm oe", pin_oe[1], 1);
    wr(CAM_IDX_TB, 32'h0070);
    repeat (3) @(posedge pclk);
    chk("pwm low", pin_out[1], 0);
    // a new duty waits in the high byte until the low byte wraps
    wr(CAM_IDX_CMP_BASE + 8'h01, 32'h0280);
    wr(CAM_IDX_TB, 32'h00FE);
    wr(CAM_IDX_CTRL, 32'h40);
    repeat (10) @(posedge pclk);
    wr(CAM_IDX_CTRL, 32'h0);
    rd("pwm reload", CAM_IDX_CMP_BASE + 8'h01, 32'h0202);
    chk("pwm new duty", pin_out[1], 1);
    chk("wdt partial", wdt_n, 2);
    stop_test();
  end
endmodule : cam_top_tb
